// [logic/lbm_pkg.sv]
/*
  constants and types shared by the backplane/segment level selector and its display memory.
  assumes a single 100 MHz display clock and synchronous inputs.
*/
package lbm_pkg;
  // ----------------------------------------------------------------
  // drive modes (code equals number of backplanes minus one)
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_STATIC = 2'h0; // one backplane
  localparam logic [1:0] MODE_MUX2   = 2'h1; // two backplanes
  localparam logic [1:0] MODE_MUX3   = 2'h2; // three backplanes
  localparam logic [1:0] MODE_MUX4   = 2'h3; // four backplanes

  // ----------------------------------------------------------------
  // output level codes; under half bias LVL_LO means the midpoint
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_GND  = 2'h0; // ground
  localparam logic [1:0] LVL_LO   = 2'h1; // one third, or one half
  localparam logic [1:0] LVL_HI   = 2'h2; // two thirds
  localparam logic [1:0] LVL_FULL = 2'h3; // full scale

  // ----------------------------------------------------------------
  // geometry and display data addresses
  // ----------------------------------------------------------------
  localparam int         NUM_BP    = 4;      // backplane outputs
  localparam int         NUM_SEG   = 36;     // segment outputs
  localparam int         ROW_BITS  = 40;     // five bytes per backplane row
  localparam int         ROW_BYTES = 5;      // bytes per row
  localparam logic [4:0] DD_FIRST  = 5'h04;  // first display data address
  localparam logic [4:0] DD_LAST   = 5'h17;  // last display data address

  // ----------------------------------------------------------------
  // timing: one backplane time slot
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SLOT_TIME_NS  = 160;
  localparam int         SLOT_CYCLES   = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SLOT_LAST     = 8'(SLOT_CYCLES - 1);

  // ----------------------------------------------------------------
  // controller state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF = 2'b01, // display disabled, outputs at ground
    ST_RUN = 2'b10  // frames running
  } lbm_state_t;

  typedef struct packed {
    lbm_state_t  st;     // enable state
    logic [1:0]  mode;   // drive mode
    logic        half;   // half bias selected
    logic [7:0]  tick;   // cycle within slot
    logic [1:0]  slot;   // active backplane slot
    logic        pol;    // frame polarity
    logic        p_run;  // pipeline copies aligned with memory data
    logic [1:0]  p_mode;
    logic        p_half;
    logic [1:0]  p_slot;
    logic        p_pol;
    logic [7:0]  bp;     // four backplane level codes
    logic [71:0] seg;    // 36 segment level codes
  } lbm_regs_t;

  localparam lbm_regs_t REGS_RST = '{st: ST_OFF, mode: MODE_MUX4, p_mode: MODE_MUX4,
                                     default: '0};
endpackage : lbm_pkg

// [logic/lbm_dispmem.sv]
/*
  display data memory: four rows of five bytes, byte write, whole-row registered read.
  assumes row and lane indices already checked by the caller.
*/
module lbm_dispmem
  import lbm_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clr,
  // byte write port
  input  wire logic                wr_en,
  input  wire logic [1:0]          wr_row,
  input  wire logic [2:0]          wr_lane,
  input  wire logic [7:0]          wr_data,
  // row read port
  input  wire logic [1:0]          rd_row,
  output logic      [ROW_BITS-1:0] rd_data
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [ROW_BITS-1:0] mem_reg [NUM_BP]; // one row per backplane

  // write, clear and registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BP; i++) begin
        mem_reg[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (clr) begin
        for (int i = 0; i < NUM_BP; i++) begin
          mem_reg[i] <= '0;
        end
      end else if (wr_en) begin
        mem_reg[wr_row][wr_lane*8 +: 8] <= wr_data;
      end
      rd_data <= mem_reg[rd_row];
    end
  end
endmodule : lbm_dispmem

// [logic/lbm_selector.sv]
/*
  level selector for a multiplexed segment display: picks a level code for four
  backplane and 36 segment outputs from drive mode, bias and display data.
  assumes an analog stage that turns level codes into voltages, a host that writes
  configuration and display bytes through synchronous strobes.
*/
module lbm_selector
  import lbm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sw_reset,
  // configuration command
  input  wire logic        cfg_wr,
  input  wire logic [1:0]  cfg_mode,
  input  wire logic        cfg_bias_half,
  input  wire logic        display_enable_bit,
  // display data write
  input  wire logic        dd_wr,
  input  wire logic [4:0]  dd_addr,
  input  wire logic [7:0]  dd_data,
  // level outputs
  output logic      [1:0]  backplane_out_0,
  output logic      [1:0]  backplane_out_1,
  output logic      [1:0]  backplane_out_2,
  output logic      [1:0]  backplane_out_3,
  output logic      [71:0] segment_out,
  // status
  output logic             bias_half_sel,
  output logic             drive_active
);
  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // logical backplane shown on physical output k
  function automatic logic [1:0] bp_map(input logic [1:0] mode, input logic [1:0] k);
    unique case (mode)
      MODE_STATIC: bp_map = 2'h0;
      MODE_MUX2:   bp_map = {1'b0, k[0]};
      MODE_MUX3:   bp_map = (k == 2'h3) ? 2'h1 : k;
      MODE_MUX4:   bp_map = k;
    endcase
  endfunction : bp_map

  // backplane level: full swing when selected, bias level otherwise
  function automatic logic [1:0] com_level(input logic sel, input logic pol,
                                           input logic half);
    if (sel) begin
      com_level = pol ? LVL_GND : LVL_FULL;
    end else if (half) begin
      com_level = LVL_LO;
    end else begin
      com_level = pol ? LVL_HI : LVL_LO;
    end
  endfunction : com_level

  // segment level: on opposes selected backplane, off tracks it
  function automatic logic [1:0] seg_level(input logic on, input logic pol,
                                           input logic two_lvl);
    if (on) begin
      seg_level = pol ? LVL_FULL : LVL_GND;
    end else if (two_lvl) begin
      seg_level = pol ? LVL_GND : LVL_FULL;
    end else begin
      seg_level = pol ? LVL_LO : LVL_HI;
    end
  endfunction : seg_level

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1; // first synchroniser stage
  logic rst_q;  // released reset used by the design

  // two-flop release of the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_q  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_q  <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // display memory
  // ----------------------------------------------------------------
  lbm_regs_t           r_reg;    // all state
  lbm_regs_t           r_next;   // next state
  logic [ROW_BITS-1:0] row_data; // row for the slot held in p_slot
  logic                dd_ok;    // address in display data range
  logic [4:0]          dd_off;   // offset from first data address
  logic [1:0]          dd_row;   // target backplane row
  logic [2:0]          dd_lane;  // target byte in row

  // split address into row and byte; out-of-range writes are dropped
  always_comb begin
    dd_ok   = (dd_addr >= DD_FIRST) && (dd_addr <= DD_LAST);
    dd_off  = dd_addr - DD_FIRST;
    dd_row  = 2'(dd_off / 5'(ROW_BYTES));
    dd_lane = 3'(dd_off % 5'(ROW_BYTES));
  end

  lbm_dispmem u_mem (
    .clk     (clk),
    .rst_n   (rst_q),
    .clr     (sw_reset),
    .wr_en   (dd_wr && dd_ok),
    .wr_row  (dd_row),
    .wr_lane (dd_lane),
    .wr_data (dd_data),
    .rd_row  (r_reg.slot),
    .rd_data (row_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // slot timer and frame polarity
    if (r_reg.st == ST_RUN) begin
      if (r_reg.tick == SLOT_LAST) begin
        r_next.tick = '0;
        if (r_reg.slot == r_reg.mode) begin
          r_next.slot = '0;
          r_next.pol  = ~r_reg.pol;
        end else begin
          r_next.slot = r_reg.slot + 2'h1;
        end
      end else begin
        r_next.tick = r_reg.tick + 8'h01;
      end
    end
    // configuration command; a mode change or start restarts the frame
    if (cfg_wr) begin
      r_next.mode = cfg_mode;
      r_next.half = cfg_bias_half;
      r_next.st   = display_enable_bit ? ST_RUN : ST_OFF;
      if (cfg_mode != r_reg.mode || r_reg.st == ST_OFF) begin
        r_next.tick = '0;
        r_next.slot = '0;
        r_next.pol  = 1'b0;
      end
    end
    // pipeline aligned with registered memory read
    r_next.p_run  = (r_reg.st == ST_RUN);
    r_next.p_mode = r_reg.mode;
    r_next.p_half = r_reg.half;
    r_next.p_slot = r_reg.slot;
    r_next.p_pol  = r_reg.pol;
    // output levels, ground while disabled
    for (int k = 0; k < NUM_BP; k++) begin
      r_next.bp[2*k +: 2] = r_reg.p_run ?
        com_level(bp_map(r_reg.p_mode, 2'(k)) == r_reg.p_slot, r_reg.p_pol,
                  r_reg.p_half || r_reg.p_mode == MODE_STATIC) : LVL_GND;
    end
    for (int j = 0; j < NUM_SEG; j++) begin
      r_next.seg[2*j +: 2] = r_reg.p_run ?
        seg_level(row_data[j], r_reg.p_pol,
                  r_reg.p_half || r_reg.p_mode == MODE_STATIC) : LVL_GND;
    end
    // software reset returns every field to its reset value
    if (sw_reset) begin
      r_next = REGS_RST;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign backplane_out_0 = r_reg.bp[1:0];
  assign backplane_out_1 = r_reg.bp[3:2];
  assign backplane_out_2 = r_reg.bp[5:4];
  assign backplane_out_3 = r_reg.bp[7:6];
  assign segment_out     = r_reg.seg;
  assign bias_half_sel   = r_reg.half;
  assign drive_active    = r_reg.p_run;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q);

  sequence frame_end_s;
    r_reg.st == ST_RUN && !cfg_wr && !sw_reset &&
    r_reg.tick == SLOT_LAST && r_reg.slot == r_reg.mode;
  endsequence

  sequence off_two_s;
    (r_reg.st == ST_OFF && !sw_reset) [*2];
  endsequence

  mux3_copy_a: assert property ((r_reg.p_run && r_reg.p_mode == MODE_MUX3)
    |=> backplane_out_3 == backplane_out_1) else $error("bp3 differs from bp1");
  mux2_pairs_a: assert property ((r_reg.p_run && r_reg.p_mode == MODE_MUX2)
    |=> backplane_out_0 == backplane_out_2 && backplane_out_1 == backplane_out_3)
    else $error("bp pairs differ");
  static_same_a: assert property ((r_reg.p_mode == MODE_STATIC)
    |=> r_reg.bp == {4{backplane_out_0}}) else $error("static bp differ");
  off_ground_a: assert property (off_two_s |=> r_reg.bp == '0 && segment_out == '0)
    else $error("outputs not grounded while off");
  half_no_hi_a: assert property ((r_reg.p_half || r_reg.p_mode == MODE_STATIC)
    |=> backplane_out_0 != LVL_HI && segment_out[1:0] != LVL_HI)
    else $error("two-thirds level under half bias");
  static_two_a: assert property ((r_reg.p_mode == MODE_STATIC)
    |=> backplane_out_0 != LVL_LO && segment_out[1:0] != LVL_LO)
    else $error("mid level in static mode");
  pol_flip_a: assert property (frame_end_s |=> r_reg.pol != $past(r_reg.pol))
    else $error("polarity did not alternate");
  seg_on_a: assert property ((r_reg.p_run && !r_reg.p_pol && row_data[0] && !sw_reset)
    |=> segment_out[1:0] == LVL_GND) else $error("on segment not at ground");
  cfg_take_a: assert property ((cfg_wr && !sw_reset)
    |=> r_reg.mode == $past(cfg_mode) && r_reg.half == $past(cfg_bias_half))
    else $error("configuration not taken");
  rst_dflt_a: assert property (!$past(rst_q) |-> r_reg.mode == MODE_MUX4 && !r_reg.half
    && r_reg.st == ST_OFF && r_reg.bp == '0) else $error("bad reset defaults");
endmodule : lbm_selector

// [verification/lbm_panel.sv]
/*
  passive panel stand-in: sums the drive across two display elements so that dc bias shows.
  assumes selector level codes and a bench that clears and opens the summing window.
*/
module lbm_panel
  import lbm_pkg::*;
(
  // clock and window control
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        acc,
  // selector outputs
  input  wire logic        half,
  input  wire logic [1:0]  bp0,
  input  wire logic [1:0]  bp1,
  input  wire logic [71:0] seg,
  // element drive sums, sixths of full scale
  output int               dc0,
  output int               dc1
);
  timeunit 1ns;
  timeprecision 1ps;

  // code to sixths; under half bias the low code is the midpoint
  function automatic int six(input logic [1:0] c, input logic h);
    return (h && c == LVL_LO) ? 3 : 2 * int'(c);
  endfunction : six

  // a liquid cell only tolerates zero average drive
  always @(posedge clk) begin
    if (clr) begin
      dc0 <= 0;
      dc1 <= 0;
    end else if (acc) begin
      dc0 <= dc0 + six(bp0, half) - six(seg[1:0], half);
      dc1 <= dc1 + six(bp1, half) - six(seg[15:14], half);
    end
  end
endmodule : lbm_panel

// [verification/lbm_selector_tb.sv]
/*
  self-checking bench for the level selector with a passive panel model.
  assumes level codes and latencies as handed over by the designer.
*/
module lbm_selector_tb
  import lbm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sw_reset = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [1:0]  cfg_mode = MODE_MUX4;
  logic        cfg_bias_half = 1'b0;
  logic        display_enable_bit = 1'b0;
  logic        dd_wr = 1'b0;
  logic [4:0]  dd_addr = 5'h00;
  logic [7:0]  dd_data = 8'h00;
  logic        pan_clr = 1'b1;
  logic        pan_acc = 1'b0;
  logic [1:0]  backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3;
  logic [71:0] segment_out;
  logic        bias_half_sel, drive_active;
  int          dc0, dc1, errors, compares, p2, p3, p4, bad;
  logic [3:0]  seen;
  logic [35:0] row [4] = '{default: '0}; // expected display bits per backplane

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  lbm_selector i_lbm_selector (.clk(clk), .rstn(rstn), .sw_reset(sw_reset), .cfg_wr(cfg_wr),
    .cfg_mode(cfg_mode), .cfg_bias_half(cfg_bias_half), .display_enable_bit(display_enable_bit),
    .dd_wr(dd_wr), .dd_addr(dd_addr), .dd_data(dd_data), .backplane_out_0(backplane_out_0),
    .backplane_out_1(backplane_out_1), .backplane_out_2(backplane_out_2),
    .backplane_out_3(backplane_out_3), .segment_out(segment_out),
    .bias_half_sel(bias_half_sel), .drive_active(drive_active));
  lbm_panel i_lbm_panel (.clk(clk), .clr(pan_clr), .acc(pan_acc), .half(bias_half_sel),
    .bp0(backplane_out_0), .bp1(backplane_out_1), .seg(segment_out), .dc0(dc0), .dc1(dc1));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // one configuration command; returns three cycles after the strobe, one cycle after restarted slot 0 levels first show
  task automatic cfg(input logic [1:0] m, input logic h, input logic en);
    cfg_mode = m;
    cfg_bias_half = h;
    display_enable_bit = en;
    cfg_wr = 1'b1;
    pan_clr = 1'b1;
    tick();
    cfg_wr = 1'b0;
    pan_clr = 1'b0;
    repeat (3) tick();
  endtask : cfg

  // display byte write, mirrored into the expected rows when in range
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int o;
    o = int'(a) - 4;
    dd_addr = a;
    dd_data = d;
    dd_wr = 1'b1;
    if (o >= 0 && o < 20) begin
      for (int i = 0; i < 8; i++) begin
        if ((o % 5) * 8 + i < NUM_SEG) row[o / 5][(o % 5) * 8 + i] = d[i];
      end
    end
    tick();
    dd_wr = 1'b0;
    tick(); // let an edge pass so the next strobe rises in a later step
  endtask : wr

  // watch n cycles: backplane pairs, levels used, and segments against rows
  task automatic observe(input int n, input logic segchk);
    logic [1:0] b [4];
    logic [1:0] e;
    seen = '0;
    p2 = 0;
    p3 = 0;
    p4 = 0;
    bad = 0;
    pan_acc = 1'b1;
    repeat (n) begin
      b = '{backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3};
      if (b[3] !== b[1]) p2++;
      if (b[0] !== b[2] || b[1] !== b[3]) p3++;
      if (b[0] !== b[1] || b[0] !== b[2] || b[0] !== b[3]) p4++;
      for (int k = 0; k < NUM_BP; k++) seen[b[k]] = 1'b1;
      for (int j = 0; j < NUM_SEG; j++) seen[segment_out[2*j+:2]] = 1'b1;
      for (int k = 0; k < NUM_BP && segchk; k++) begin
        if (b[k] === LVL_FULL || b[k] === LVL_GND) begin
          for (int j = 0; j < NUM_SEG; j++) begin
            e = row[k][j] ? ((b[k] === LVL_FULL) ? LVL_GND : LVL_FULL)
                          : ((b[k] === LVL_FULL) ? LVL_HI : LVL_LO);
            if (segment_out[2*j+:2] !== e) bad++;
          end
        end
      end
      tick();
    end
    pan_acc = 1'b0;
  endtask : observe

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("ground", 8'h00, 8'(|{backplane_out_0, backplane_out_1, backplane_out_2,
        backplane_out_3, segment_out}));
    chk("active", 8'h00, 8'(drive_active));
    chk("half", 8'h00, 8'(bias_half_sel));
    $display("done reset");
  endtask : t_reset

  task automatic t_static();
    // one lit element, so a polarity that never swaps leaves a drive offset
    wr(5'h04, 8'h01);
    cfg(MODE_STATIC, 1'b0, 1'b1);
    chk("active", 8'h01, 8'(drive_active));
    observe(2 * SLOT_CYCLES, 1'b0);
    chk("static pairs", 8'h00, 8'(p4));
    chk("static levels", 8'h09, 8'(seen));
    chk("dc", 8'h00, 8'(dc0));
    $display("done static");
  endtask : t_static

  task automatic t_mux2();
    for (int h = 1; h >= 0; h--) begin
      cfg(MODE_MUX2, 1'(h), 1'b1);
      chk("half", 8'(h), 8'(bias_half_sel));
      observe(4 * SLOT_CYCLES, 1'b0);
      chk("mux2 pairs", 8'h00, 8'(p3));
      chk("mux2 levels", h ? 8'h0b : 8'h0f, 8'(seen));
      chk("dc", 8'h00, 8'(dc0));
    end
    $display("done mux2");
  endtask : t_mux2

  task automatic t_mux3();
    cfg(MODE_MUX3, 1'b0, 1'b1);
    observe(6 * SLOT_CYCLES, 1'b0);
    chk("mux3 pair", 8'h00, 8'(p2));
    chk("mux3 levels", 8'h0f, 8'(seen));
    $display("done mux3");
  endtask : t_mux3

  task automatic t_data();
    wr(5'h04, 8'h01);
    wr(5'h09, 8'h80);
    wr(5'h17, 8'h0f);
    wr(5'h18, 8'hff); // out of range, dropped
    wr(5'h03, 8'hff); // out of range, dropped
    cfg(MODE_MUX4, 1'b0, 1'b1);
    observe(8 * SLOT_CYCLES, 1'b1);
    chk("segments", 8'h00, 8'(bad));
    chk("dc on", 8'h00, 8'(dc1));
    $display("done data");
  endtask : t_data

  task automatic t_mux4_half();
    cfg(MODE_MUX4, 1'b1, 1'b1);
    chk("half", 8'h01, 8'(bias_half_sel));
    observe(8 * SLOT_CYCLES, 1'b0);
    chk("mux4h levels", 8'h0b, 8'(seen));
    chk("dc on", 8'h00, 8'(dc1));
    $display("done mux4 half");
  endtask : t_mux4_half

  task automatic t_off();
    cfg(MODE_MUX4, 1'b0, 1'b0);
    chk("active", 8'h00, 8'(drive_active));
    observe(2 * SLOT_CYCLES, 1'b0);
    chk("off levels", 8'h01, 8'(seen));
    $display("done off");
  endtask : t_off

  task automatic t_swreset();
    cfg(MODE_MUX2, 1'b1, 1'b1);
    sw_reset = 1'b1;
    tick();
    sw_reset = 1'b0;
    tick();
    chk("active", 8'h00, 8'(drive_active));
    chk("half", 8'h00, 8'(bias_half_sel));
    row = '{default: '0};
    cfg(MODE_MUX4, 1'b0, 1'b1);
    observe(8 * SLOT_CYCLES, 1'b1);
    chk("cleared", 8'h00, 8'(bad));
    $display("done sw reset");
  endtask : t_swreset

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) tick();
    t_reset();
    t_static();
    t_mux2();
    t_mux3();
    t_data();
    t_mux4_half();
    t_off();
    t_swreset();
    end_sim();
  end

  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule : lbm_selector_tb
